// *** ceo_pkg.sv ***
// Shared constants and types for the clock output enable serial port
package ceo_pkg;

  // ----------------------------------------------------------------
  // Device register layout
  // ----------------------------------------------------------------
  localparam int         REG_COUNT   = 3;
  localparam int         OUT_COUNT   = 13;
  localparam int         NIBBLE      = 4;
  localparam logic [6:0] DEV_ADDR7   = 7'h69;
  localparam logic [7:0] ADDR_WRITE  = 8'hd2;
  localparam logic [7:0] ADDR_READ   = 8'hd3;
  localparam logic [7:0] CMD_BYTE    = 8'h00;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [7:0] RST_GROUP0  = 8'hcf;
  localparam logic [7:0] RST_GROUP1  = 8'hff;
  localparam logic [7:0] RST_GROUP2  = 8'h40;
  localparam logic [7:0] READ_BEYOND = 8'h00;
  localparam int EN0_LOW_LSB   = 0;
  localparam int EN0_OUT4_BIT  = 6;
  localparam int EN0_OUT5_BIT  = 7;
  localparam int EN1_OUT6_BIT  = 0;
  localparam int EN1_OUT7_BIT  = 1;
  localparam int EN1_HIGH_LSB  = 4;
  localparam int EN2_OUT12_BIT = 6;

  // ----------------------------------------------------------------
  // Controller register map and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] MREG_CTRL    = 3'h0;
  localparam logic [2:0] MREG_WDATA0  = 3'h1;
  localparam logic [2:0] MREG_WDATA2  = 3'h3;
  localparam logic [2:0] MREG_RDATA0  = 3'h4;
  localparam logic [2:0] MREG_RDATA2  = 3'h6;
  localparam logic [2:0] MREG_STATUS  = 3'h7;
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_READ_BIT  = 1;
  localparam int CTRL_COUNT_LSB = 2;
  localparam int SYS_CLK_HZ     = 125_000_000;
  localparam int SCL_HZ         = 100_000;
  localparam int QUARTER_CYCLES = SYS_CLK_HZ / (4 * SCL_HZ);

  typedef logic [REG_COUNT-1:0][7:0] ceo_regs_type;

  typedef enum logic [1:0] {
    HDR_ADDR  = 2'h0,
    HDR_CMD   = 2'h1,
    HDR_COUNT = 2'h2,
    HDR_DATA  = 2'h3
  } ceo_hdr_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } ceo_dev_state_type;

  typedef enum logic [3:0] {
    M_IDLE  = 4'h1,
    M_START = 4'h2,
    M_BIT   = 4'h4,
    M_STOP  = 4'h8
  } ceo_mst_state_type;

endpackage

// *** ceo_link_if.sv ***
// Two-wire link between the controller and the clock buffer device
`timescale 1ns/10ps
interface ceo_link_if;
  logic serial_clock_pin;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_d_out;
  logic sda_d_oe;
  logic serial_data_pin;

  // Open drain wire with pull-up: low while any enabled driver sends low
  assign serial_data_pin = ~((sda_m_oe & ~sda_m_out) | (sda_d_oe & ~sda_d_out));

  modport master (output serial_clock_pin, output sda_m_out, output sda_m_oe,
                  input serial_data_pin);
  modport device (input serial_clock_pin, input serial_data_pin,
                  output sda_d_out, output sda_d_oe);
endinterface

// *** ceo_device.sv ***
// Clock buffer device: serial slave port, enable registers and output gating
`timescale 1ns/10ps
module ceo_device (
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          ref_clk_in,
  ceo_link_if.device                         link,
  output logic [ceo_pkg::OUT_COUNT-1:0]      sdram_clk_out,
  output logic [ceo_pkg::OUT_COUNT-1:0]      enable_state_out
);
  import ceo_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              scl_s1;
    logic              scl_s2;
    logic              scl_d;
    logic              sda_s1;
    logic              sda_s2;
    logic              sda_d;
    ceo_dev_state_type state;
    ceo_hdr_type       hdr;
    logic [3:0]        bit_cnt;
    logic [7:0]        shift;
    logic [1:0]        reg_idx;
    logic              rw;
    logic              sda_oe;
    ceo_regs_type      regs;
    logic [OUT_COUNT-1:0] enables;
  } ceo_dev_type;

  typedef struct packed {
    logic [OUT_COUNT-1:0] sync1;
    logic [OUT_COUNT-1:0] sync2;
  } ceo_gate_type;

  localparam ceo_regs_type RST_REGS = {RST_GROUP2, RST_GROUP1, RST_GROUP0};

  ceo_dev_type  r_reg;
  ceo_dev_type  r_next;
  ceo_gate_type g_reg;
  ceo_gate_type g_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [OUT_COUNT-1:0] enable_map(input ceo_regs_type regs);
    logic [OUT_COUNT-1:0] en;
    en = '0;
    en[3:0]  = regs[0][EN0_LOW_LSB +: NIBBLE];
    en[4]    = regs[0][EN0_OUT4_BIT];
    en[5]    = regs[0][EN0_OUT5_BIT];
    en[6]    = regs[1][EN1_OUT6_BIT];
    en[7]    = regs[1][EN1_OUT7_BIT];
    en[11:8] = regs[1][EN1_HIGH_LSB +: NIBBLE];
    en[12]   = regs[2][EN2_OUT12_BIT];
    return en;
  endfunction

  // Byte returned for a read slot; slots past the last register read as zero
  function automatic logic [7:0] read_byte(input ceo_regs_type regs,
                                           input logic [1:0] idx);
    logic [7:0] b;
    b = READ_BEYOND;
    if (idx < 2'(REG_COUNT)) begin
      b = regs[idx];
    end
    return b;
  endfunction

  function automatic logic [1:0] next_idx(input logic [1:0] idx);
    logic [1:0] n;
    n = idx;
    if (idx != 2'(REG_COUNT)) begin
      n = idx + 2'h1;
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Serial slave, oversampled on the system clock
  // ----------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise   = r_reg.scl_s2 & ~r_reg.scl_d;
  assign scl_fall   = ~r_reg.scl_s2 & r_reg.scl_d;
  assign start_seen = r_reg.scl_s2 & r_reg.scl_d & r_reg.sda_d & ~r_reg.sda_s2;
  assign stop_seen  = r_reg.scl_s2 & r_reg.scl_d & ~r_reg.sda_d & r_reg.sda_s2;

  always_comb begin
    logic [7:0] tx;
    tx = '0;
    r_next = r_reg;
    r_next.scl_s1  = link.serial_clock_pin;
    r_next.scl_s2  = r_reg.scl_s1;
    r_next.scl_d   = r_reg.scl_s2;
    r_next.sda_s1  = link.serial_data_pin;
    r_next.sda_s2  = r_reg.sda_s1;
    r_next.sda_d   = r_reg.sda_s2;
    r_next.enables = enable_map(r_reg.regs);
    if (stop_seen) begin
      r_next.state  = ST_IDLE;
      r_next.sda_oe = 1'b0;
    end else if (start_seen) begin
      r_next.state   = ST_RX;
      r_next.hdr     = HDR_ADDR;
      r_next.bit_cnt = '0;
      r_next.reg_idx = '0;
      r_next.rw      = 1'b0;
      r_next.sda_oe  = 1'b0;
    end else begin
      unique case (r_reg.state)
        ST_IDLE: begin
          r_next.sda_oe = 1'b0;
        end
        ST_RX: begin
          // Data is taken on the rising clock, stable while high
          if (scl_rise) begin
            r_next.shift   = {r_reg.shift[6:0], r_reg.sda_s2};
            r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
          end else if (scl_fall && r_reg.bit_cnt == BYTE_BITS) begin
            r_next.sda_oe = 1'b1;
            r_next.state  = ST_ACK;
            unique case (r_reg.hdr)
              HDR_ADDR: begin
                if (r_reg.shift[7:1] == DEV_ADDR7) begin
                  r_next.rw = r_reg.shift[0];
                end else begin
                  r_next.sda_oe = 1'b0;
                  r_next.state  = ST_IDLE;
                end
              end
              HDR_CMD, HDR_COUNT: begin
                r_next.sda_oe = 1'b1;
              end
              HDR_DATA: begin
                if (r_reg.reg_idx < 2'(REG_COUNT)) begin
                  r_next.regs[r_reg.reg_idx] = r_reg.shift;
                end
                r_next.reg_idx = next_idx(r_reg.reg_idx);
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            r_next.bit_cnt = '0;
            if (r_reg.rw) begin
              tx              = read_byte(r_reg.regs, r_reg.reg_idx);
              r_next.shift    = tx;
              r_next.reg_idx  = next_idx(r_reg.reg_idx);
              r_next.sda_oe   = ~tx[7];
              r_next.state    = ST_TX;
            end else begin
              r_next.sda_oe = 1'b0;
              r_next.state  = ST_RX;
              if (r_reg.hdr != HDR_DATA) begin
                r_next.hdr = ceo_hdr_type'(r_reg.hdr + 2'h1);
              end
            end
          end
        end
        ST_TX: begin
          // Next bit is put out right after the falling clock
          if (scl_fall) begin
            r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
            if (r_reg.bit_cnt == BYTE_BITS - 4'h1) begin
              r_next.sda_oe = 1'b0;
              r_next.state  = ST_MACK;
            end else begin
              r_next.shift  = {r_reg.shift[6:0], 1'b0};
              r_next.sda_oe = ~r_reg.shift[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise && r_reg.sda_s2) begin
            r_next.state = ST_IDLE;
          end else if (scl_fall) begin
            tx             = read_byte(r_reg.regs, r_reg.reg_idx);
            r_next.shift   = tx;
            r_next.reg_idx = next_idx(r_reg.reg_idx);
            r_next.bit_cnt = '0;
            r_next.sda_oe  = ~tx[7];
            r_next.state   = ST_TX;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_reg         <= '0;
      r_reg.scl_s1  <= 1'b1;
      r_reg.scl_s2  <= 1'b1;
      r_reg.scl_d   <= 1'b1;
      r_reg.sda_s1  <= 1'b1;
      r_reg.sda_s2  <= 1'b1;
      r_reg.sda_d   <= 1'b1;
      r_reg.state   <= ST_IDLE;
      r_reg.hdr     <= HDR_ADDR;
      r_reg.regs    <= RST_REGS;
      r_reg.enables <= '1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.sda_d_out  = 1'b0;
  assign link.sda_d_oe   = r_reg.sda_oe;
  assign enable_state_out = r_reg.enables;

  // ----------------------------------------------------------------
  // Output gating in the reference clock domain
  // ----------------------------------------------------------------
  // Enables re-timed on the falling reference edge so that they only
  // change while the reference is low: no runt pulses on any output.
  always_comb begin
    g_next       = g_reg;
    g_next.sync1 = r_reg.enables;
    g_next.sync2 = g_reg.sync1;
  end

  always_ff @(negedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      g_reg <= '1;
    end else begin
      g_reg <= g_next;
    end
  end

  assign sdram_clk_out = {OUT_COUNT{ref_clk_in}} & g_reg.sync2;

endmodule

// *** ceo_master.sv ***
// Serial bus controller that programs and reads back the clock buffer
`timescale 1ns/10ps
module ceo_master #(
  parameter int QUARTER = ceo_pkg::QUARTER_CYCLES
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  ceo_link_if.master       link,
  input  wire logic [2:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [7:0]       rdata_out,
  output logic             busy_out
);
  import ceo_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ceo_mst_state_type state;
    logic              scl;
    logic              sda_oe;
    logic              sda_s1;
    logic              sda_s2;
    logic [15:0]       div_cnt;
    logic [1:0]        quarter;
    logic [3:0]        bit_cnt;
    logic [2:0]        byte_num;
    logic [2:0]        last_byte;
    logic [1:0]        count;
    logic              rw;
    logic              nack;
    logic [7:0]        shift;
    ceo_regs_type      wdata;
    ceo_regs_type      rdata;
    logic [7:0]        rdata_q;
  } ceo_mst_type;

  ceo_mst_type r_reg;
  ceo_mst_type r_next;

  // Byte sent in slot num: address, command, count, then register data
  function automatic logic [7:0] tx_byte(input logic [2:0] num, input logic rw,
                                         input logic [1:0] cnt,
                                         input ceo_regs_type wd);
    logic [7:0] b;
    b = CMD_BYTE;
    if (num == 3'h0) begin
      b = rw ? ADDR_READ : ADDR_WRITE;
    end else if (num == 3'h2) begin
      b = {6'h00, cnt};
    end else if (num > 3'h2) begin
      b = wd[2'(num - 3'h3)];
    end
    return b;
  endfunction

  logic tick;
  logic txing;
  assign tick  = r_reg.div_cnt == 16'(QUARTER - 1);
  assign txing = ~r_reg.rw | (r_reg.byte_num == 3'h0);

  // ----------------------------------------------------------------
  // Register port and bit sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] cnt;
    cnt = '0;
    r_next = r_reg;
    r_next.sda_s1  = link.serial_data_pin;
    r_next.sda_s2  = r_reg.sda_s1;
    r_next.div_cnt = tick ? '0 : r_reg.div_cnt + 16'h1;
    if (rd_in) begin
      r_next.rdata_q = '0;
      if (addr_in >= MREG_RDATA0 && addr_in <= MREG_RDATA2) begin
        r_next.rdata_q = r_reg.rdata[2'(addr_in - MREG_RDATA0)];
      end else if (addr_in >= MREG_WDATA0 && addr_in <= MREG_WDATA2) begin
        r_next.rdata_q = r_reg.wdata[2'(addr_in - MREG_WDATA0)];
      end else if (addr_in == MREG_STATUS) begin
        r_next.rdata_q = {6'h00, r_reg.nack, r_reg.state != M_IDLE};
      end
    end
    if (wr_in && addr_in >= MREG_WDATA0 && addr_in <= MREG_WDATA2) begin
      r_next.wdata[2'(addr_in - MREG_WDATA0)] = wdata_in;
    end
    unique case (r_reg.state)
      M_IDLE: begin
        r_next.scl    = 1'b1;
        r_next.sda_oe = 1'b0;
        if (wr_in && addr_in == MREG_CTRL && wdata_in[CTRL_GO_BIT]) begin
          cnt = wdata_in[CTRL_COUNT_LSB +: 2];
          r_next.rw = wdata_in[CTRL_READ_BIT];
          if (wdata_in[CTRL_READ_BIT] && cnt == 2'h0) begin
            cnt = 2'h1;
          end
          r_next.count     = cnt;
          // Every register byte before the target is always sent
          r_next.last_byte = wdata_in[CTRL_READ_BIT] ? {1'b0, cnt} : 3'h2 + {1'b0, cnt};
          r_next.nack      = 1'b0;
          r_next.quarter   = '0;
          r_next.div_cnt   = '0;
          r_next.state     = M_START;
        end
      end
      M_START: begin
        if (tick) begin
          r_next.quarter = r_reg.quarter + 2'h1;
          if (r_reg.quarter == 2'h2) begin
            r_next.sda_oe = 1'b1;
          end else if (r_reg.quarter == 2'h3) begin
            r_next.scl      = 1'b0;
            r_next.bit_cnt  = '0;
            r_next.byte_num = '0;
            r_next.shift    = tx_byte(3'h0, r_reg.rw, r_reg.count, r_reg.wdata);
            r_next.state    = M_BIT;
          end
        end
      end
      M_BIT: begin
        if (tick) begin
          r_next.quarter = r_reg.quarter + 2'h1;
          unique case (r_reg.quarter)
            2'h0: r_next.scl = 1'b0;
            2'h1: begin
              // Data moves a quarter after the falling clock, never beside it
              if (r_reg.bit_cnt < BYTE_BITS) begin
                r_next.sda_oe = txing & ~r_reg.shift[7];
              end else begin
                r_next.sda_oe = ~txing & (r_reg.byte_num != r_reg.last_byte);
              end
            end
            2'h2: r_next.scl = 1'b1;
            2'h3: begin
              r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
              if (r_reg.bit_cnt < BYTE_BITS) begin
                r_next.shift = {r_reg.shift[6:0], r_reg.sda_s2};
              end else begin
                r_next.bit_cnt = '0;
                if (!txing) begin
                  r_next.rdata[2'(r_reg.byte_num - 3'h1)] = r_reg.shift;
                end
                if (txing && r_reg.sda_s2) begin
                  r_next.nack  = 1'b1;
                  r_next.state = M_STOP;
                end else if (r_reg.byte_num == r_reg.last_byte) begin
                  r_next.state = M_STOP;
                end else begin
                  r_next.byte_num = r_reg.byte_num + 3'h1;
                  r_next.shift    = tx_byte(r_reg.byte_num + 3'h1, r_reg.rw,
                                            r_reg.count, r_reg.wdata);
                end
              end
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          r_next.quarter = r_reg.quarter + 2'h1;
          unique case (r_reg.quarter)
            2'h0: r_next.scl    = 1'b0;
            2'h1: r_next.sda_oe = 1'b1;
            2'h2: r_next.scl    = 1'b1;
            2'h3: begin
              r_next.sda_oe = 1'b0;
              r_next.state  = M_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_reg        <= '0;
      r_reg.state  <= M_IDLE;
      r_reg.scl    <= 1'b1;
      r_reg.sda_s1 <= 1'b1;
      r_reg.sda_s2 <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.serial_clock_pin = r_reg.scl;
  assign link.sda_m_out        = 1'b0;
  assign link.sda_m_oe         = r_reg.sda_oe;
  assign rdata_out             = r_reg.rdata_q;
  assign busy_out              = r_reg.state != M_IDLE;

endmodule

// *** ceo_link_monitor.sv ***
// Checker for the two-wire link between controller and clock buffer
`timescale 1ns/10ps
module ceo_link_monitor #(
  parameter int QUARTER = 8
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic serial_clock_pin,
  input wire logic sda_m_out,
  input wire logic sda_m_oe,
  input wire logic sda_d_out,
  input wire logic sda_d_oe,
  input wire logic serial_data_pin
);
  import ceo_pkg::*;
  localparam int START_MAX = QUARTER + 4;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_cnt;
  logic [3:0] byte_cnt;
  logic [7:0] shift;
  logic [7:0] first;
  wire        start   = serial_clock_pin && scl_q && sda_q && !serial_data_pin;
  wire        stop    = serial_clock_pin && scl_q && !sda_q && serial_data_pin;
  wire        rise    = serial_clock_pin && !scl_q;
  wire        ack     = rise && (bit_cnt == 4'h8);
  wire        adr_ack = ack && (byte_cnt == 4'h0);
  wire        body    = ack && (byte_cnt != 4'h0);

  // ----------------------------------------------------------------
  // Bit and byte position since the last start
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      bit_cnt  <= 4'h0;
      byte_cnt <= 4'h0;
      shift    <= 8'h00;
      first    <= 8'h00;
    end else begin
      scl_q <= serial_clock_pin;
      sda_q <= serial_data_pin;
      if (start) begin
        bit_cnt  <= 4'h0;
        byte_cnt <= 4'h0;
      end else if (ack) begin
        bit_cnt  <= 4'h0;
        byte_cnt <= byte_cnt + {3'h0, byte_cnt != 4'hf};
        if (byte_cnt == 4'h0) begin
          first <= shift;
        end
      end else if (rise) begin
        bit_cnt <= bit_cnt + 4'h1;
        shift   <= {shift[6:0], serial_data_pin};
      end
    end
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // ----------------------------------------------------------------
  // Link rules
  // ----------------------------------------------------------------
  addr_ack_a: assert property (adr_ack && shift[7:1] == DEV_ADDR7
                               |-> sda_d_oe && !serial_data_pin)
    else $error("own address not acknowledged");
  addr_ignore_a: assert property (adr_ack && shift[7:1] != DEV_ADDR7
                                  |-> !sda_d_oe)
    else $error("foreign address acknowledged");
  byte_ack_a: assert property (body && first == ADDR_WRITE |-> sda_d_oe && !sda_m_oe)
    else $error("written byte not acknowledged");
  mack_free_a: assert property (body && first == ADDR_READ |-> !sda_d_oe)
    else $error("device drives master acknowledge slot");
  read_drive_a: assert property (rise && bit_cnt inside {[1:7]} && first == ADDR_READ
                                 && byte_cnt != 4'h0 |-> !sda_m_oe)
    else $error("master drives read data bit");
  dev_stable_a: assert property (serial_clock_pin && scl_q |-> $stable(sda_d_oe))
    else $error("device data changed while clock high");
  start_seq_a: assert property (start |-> ##[1:START_MAX] !serial_clock_pin)
    else $error("no clock after start");
  stop_idle_a: assert property (stop |-> (serial_clock_pin && !sda_d_oe) [*8])
    else $error("bus not idle after stop");
  foreign_off_a: assert property (body && first[7:1] != DEV_ADDR7 |-> !sda_d_oe)
    else $error("device answers after foreign address");
  drive_low_a: assert property (!(sda_d_oe && sda_d_out) && !(sda_m_oe && sda_m_out))
    else $error("open drain driver sends high");

  cover property (adr_ack && shift == ADDR_WRITE);
  cover property (adr_ack && shift == ADDR_READ);
  cover property (stop);
endmodule

// *** clock_output_enable_i2c_bench.sv ***
// Self-checking bench: controller programs and reads back the clock buffer
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module clock_output_enable_i2c_bench;
  import ceo_pkg::*;
  logic        sys_clk;
  logic        ref_clk;
  logic        rst_n;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        busy;
  logic [12:0] sdram;
  logic [12:0] enable;
  int          fail_count;
  int          num_checks;

  ceo_link_if ceo_link_if_i ();
  ceo_master #(.QUARTER(8)) ceo_master_i (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .link(ceo_link_if_i), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .busy_out(busy));
  ceo_device ceo_device_i (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .ref_clk_in(ref_clk),
    .link(ceo_link_if_i), .sdram_clk_out(sdram), .enable_state_out(enable));
  ceo_link_monitor #(.QUARTER(8)) ceo_link_monitor_i (.sys_clk_in(sys_clk),
    .rst_n_in(rst_n), .serial_clock_pin(ceo_link_if_i.serial_clock_pin),
    .sda_m_out(ceo_link_if_i.sda_m_out), .sda_m_oe(ceo_link_if_i.sda_m_oe),
    .sda_d_out(ceo_link_if_i.sda_d_out), .sda_d_oe(ceo_link_if_i.sda_d_oe),
    .serial_data_pin(ceo_link_if_i.serial_data_pin));

  // ----------------------------------------------------------------
  // Clocks and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    ref_clk = 1'b0;
    #5.3;
    forever #32 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    results();
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic results();
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Start a transfer and wait for the stop, bounded
  task automatic transfer(input logic rdf, input logic [1:0] n);
    int         k;
    logic [7:0] s;
    k = 0;
    wr_reg(MREG_CTRL, {4'h0, n, rdf, 1'b1});
    repeat (2) @(posedge sys_clk);
    `CHK(busy, 1'b1)
    while (busy === 1'b1 && k < 5000) begin
      @(posedge sys_clk);
      k++;
    end
    rd_reg(MREG_STATUS, s);
    `CHK(s[1:0], 2'b00)
  endtask

  task automatic load_groups(input ceo_regs_type g, input logic [1:0] n);
    for (int i = 0; i < REG_COUNT; i++) wr_reg(MREG_WDATA0 + 3'(i), g[i]);
    transfer(1'b0, n);
  endtask

  task automatic readback(input ceo_regs_type e);
    logic [7:0] d;
    transfer(1'b1, 2'h3);
    for (int i = 0; i < REG_COUNT; i++) begin
      rd_reg(MREG_RDATA0 + 3'(i), d);
      `CHK(d, e[i])
    end
  endtask

  function automatic logic [12:0] en_of(input ceo_regs_type g);
    return {g[2][6], g[1][7:4], g[1][1:0], g[0][7:6], g[0][3:0]};
  endfunction

  // Enabled outputs copy the reference while high; all outputs sit low while it is low
  task automatic check_outs(input logic [12:0] e);
    repeat (3) @(negedge ref_clk);
    @(posedge ref_clk);
    #8 `CHK(sdram, e)
    @(negedge ref_clk);
    #8 `CHK(sdram, 13'h0000)
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    fail_count = 0;
    num_checks = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    `CHK(enable, 13'h1fff)
    check_outs(13'h1fff);
    load_groups({8'hbf, 8'h96, 8'h5a}, 2'h3);
    `CHK(enable, en_of({8'hbf, 8'h96, 8'h5a}))
    check_outs(en_of({8'hbf, 8'h96, 8'h5a}));
    readback({8'hbf, 8'h96, 8'h5a});
    load_groups({8'h00, 8'h00, 8'hff}, 2'h1);
    readback({8'hbf, 8'h96, 8'hff});
    load_groups({8'h11, 8'h22, 8'h33}, 2'h0);
    readback({8'hbf, 8'h96, 8'hff});
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    `CHK(enable, 13'h1fff)
    readback({RST_GROUP2, RST_GROUP1, RST_GROUP0});
    results();
  end
endmodule
